/* File: logic/sdl_pkg.sv */
// constants and types shared by the serial dac word loader
package sdl_pkg;
  localparam int          SDL_FRAME_BITS  = 16;          // bits per frame
  localparam int          SDL_CODE_BITS   = 12;          // bits kept for the converter
  localparam int          SDL_CNT_W       = 5;           // bit counter width
  localparam logic [4:0]  SDL_LAST_BIT    = 5'h10;       // count at sixteenth edge
  localparam logic [11:0] SDL_CODE_RESET  = 12'h000;     // latch value after clear
  localparam logic [11:0] SDL_MSB_FLIP    = 12'h800;     // msb inversion mask
  localparam int          SDL_FIFO_DEPTH  = 16;          // words buffered
  localparam int          SDL_SYNC_STAGES = 3;           // pin synchroniser depth
  // link state, gray coded along idle -> shift -> wait
  typedef enum logic [1:0] {
    SDL_IDLE  = 2'b00,
    SDL_SHIFT = 2'b01,
    SDL_WAIT  = 2'b11
  } sdl_state_t;
endpackage : sdl_pkg

/* File: logic/sdl_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sdl_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,     // system clock
  input  wire logic             i_reset,   // synchronous reset
  input  wire logic             i_ce,      // clock enable
  input  wire logic             i_valid,   // write request
  output logic                  o_ready,   // room available
  input  wire logic [WIDTH-1:0] i_data,    // write data
  output logic                  o_valid,   // data available
  input  wire logic             i_ready,   // reader takes word
  output logic      [WIDTH-1:0] o_data     // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             do_wr;
  logic             do_rd;

  // full when pointers differ only in the wrap bit
  assign o_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign o_valid = (wr_ptr != rd_ptr);
  assign do_wr   = i_ce && i_valid && o_ready;
  assign do_rd   = i_ce && o_valid && i_ready;
  assign o_data  = mem[rd_ptr[AW-1:0]];

  // storage, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end

  // pointers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // sdl_fifo
`default_nettype wire

/* File: logic/sdl_loader.sv */
// serial dac word loader: frame capture, code mapping and dac latch
`timescale 1ns/1ps
`default_nettype none
module sdl_loader
  import sdl_pkg::*;
(
  input  wire logic        i_clk,                 // 20 mhz system clock
  input  wire logic        i_reset,               // synchronous, active high
  input  wire logic        i_ce,                  // clock enable, freezes all state
  input  wire logic        i_shift_clk,           // host shift clock pin
  input  wire logic        i_serial_data_in,      // host serial data pin
  input  wire logic        i_frame_sync_n,        // host frame sync, active low
  input  wire logic        i_latch_load_n,        // latch-load pin, active low
  input  wire logic        i_latch_clear_n,       // clear pin, active low
  input  wire logic        i_code_format_select,  // high: two's complement
  input  wire logic        i_bipolar_range,       // high: bipolar output range
  input  wire logic        i_chain_mode_enable,   // high: counter gate off
  input  wire logic        i_code_ready,          // converter takes code from fifo
  output logic             o_code_valid,          // fifo holds a code
  output logic [11:0]      o_dac_code,            // fifo head code
  output logic [11:0]      o_dac_latch,           // current dac latch contents
  output logic             o_deferred,            // frame waits for latch-load edge
  output logic             o_overflow             // sticky: update lost on full fifo
);
  // three-stage synchronisers for all pins; stage 0 is read only by stage 1
  logic [SDL_SYNC_STAGES-1:0] sck_s, sdi_s, fs_s, ld_s, clr_s;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sck_s <= '0;
      sdi_s <= '0;
      fs_s  <= '1;
      ld_s  <= '1;
      clr_s <= '1;
    end else if (i_ce) begin
      sck_s <= {sck_s[1:0], i_shift_clk};
      sdi_s <= {sdi_s[1:0], i_serial_data_in};
      fs_s  <= {fs_s[1:0], i_frame_sync_n};
      ld_s  <= {ld_s[1:0], i_latch_load_n};
      clr_s <= {clr_s[1:0], i_latch_clear_n};
    end
  end

  // filtered levels change once stages two and three agree
  logic sck_f, fs_f, ld_f, clr_f;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sck_f <= 1'b0;
      fs_f  <= 1'b1;
      ld_f  <= 1'b1;
      clr_f <= 1'b1;
    end else if (i_ce) begin
      if (sck_s[1] == sck_s[2]) sck_f <= sck_s[2];
      if (fs_s[1] == fs_s[2])   fs_f  <= fs_s[2];
      if (ld_s[1] == ld_s[2])   ld_f  <= ld_s[2];
      if (clr_s[1] == clr_s[2]) clr_f <= clr_s[2];
    end
  end

  // edge events on the filtered levels
  logic sck_fall, fs_fall, ld_fall;
  assign sck_fall = sck_f && (sck_s[1] == sck_s[2]) && !sck_s[2];
  assign fs_fall  = fs_f && (fs_s[1] == fs_s[2]) && !fs_s[2];
  assign ld_fall  = ld_f && (ld_s[1] == ld_s[2]) && !ld_s[2];
  // data sits three stages deep, matching the clock's agreeing stage
  logic sdi_bit;
  assign sdi_bit = sdi_s[2];

  // maps the 12 kept bits to a converter code per format
  function automatic logic [11:0] map_code(input logic [11:0] raw, input logic twos,
                                           input logic bip);
    if (twos) begin
      map_code = raw;
    end else if (bip) begin
      map_code = raw ^ SDL_MSB_FLIP;
    end else begin
      map_code = raw;
    end
  endfunction

  sdl_state_t            state, next_state;
  logic [SDL_CNT_W-1:0]  bit_cnt;
  logic [SDL_FRAME_BITS-1:0] shreg;
  logic                  auto_mode;
  logic                  word_done;
  logic                  shift_en;
  logic                  take_bit;

  // gate: chain mode keeps shifting past sixteen
  assign shift_en = i_chain_mode_enable || (bit_cnt < SDL_LAST_BIT);
  assign take_bit = (state == SDL_SHIFT) && !fs_f && sck_fall && shift_en;
  assign word_done = take_bit && (bit_cnt == SDL_LAST_BIT - 5'h01);

  // frame state machine
  always_comb begin
    next_state = state;
    case (state)
      SDL_IDLE:  if (fs_fall) next_state = SDL_SHIFT;
      SDL_SHIFT: if (fs_f) next_state = SDL_WAIT;
      SDL_WAIT:  next_state = SDL_IDLE;
      default:   next_state = SDL_IDLE;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) state <= SDL_IDLE;
    else if (i_ce) state <= next_state;
  end

  // bit counter cleared while frame sync is high
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bit_cnt <= '0;
    end else if (i_ce) begin
      if (fs_f) begin
        bit_cnt <= '0;
      end else if (take_bit && bit_cnt != SDL_LAST_BIT) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // shift register, msb first so lsb lands last in bit 0
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      shreg <= '0;
    end else if (i_ce && take_bit) begin
      shreg <= {shreg[SDL_FRAME_BITS-2:0], sdi_bit};
    end
  end

  // update mode caught when the frame opens
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      auto_mode <= 1'b1;
    end else if (i_ce && fs_fall) begin
      auto_mode <= !ld_f;
    end
  end

  // word that waits for a latch-load edge; only full words qualify
  logic [11:0] next_word;
  assign next_word = {shreg[SDL_CODE_BITS-2:0], sdi_bit};
  logic [11:0] held_word;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_deferred <= 1'b0;
      held_word  <= SDL_CODE_RESET;
    end else if (i_ce) begin
      if (word_done && !auto_mode) begin
        o_deferred <= 1'b1;
        held_word  <= next_word;
      end else if (ld_fall || !clr_f || fs_fall) begin
        o_deferred <= 1'b0;
      end
    end
  end

  // one update request per latch event
  logic        upd;
  logic [11:0] upd_code;
  assign upd = (word_done && auto_mode) || (ld_fall && o_deferred);
  assign upd_code = map_code((word_done && auto_mode) ? next_word : held_word,
                             i_code_format_select, i_bipolar_range);

  // dac latch; clear bypasses the shifter and wins over an update
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_dac_latch <= SDL_CODE_RESET;
    end else if (i_ce) begin
      if (!clr_f) begin
        o_dac_latch <= SDL_CODE_RESET;
      end else if (upd) begin
        o_dac_latch <= upd_code;
      end
    end
  end

  // updates also feed the converter through a buffer; a full buffer drops
  logic fifo_ready;
  always_ff @(posedge i_clk) begin
    if (i_reset) o_overflow <= 1'b0;
    else if (i_ce && upd && clr_f && !fifo_ready) o_overflow <= 1'b1;
  end

  sdl_fifo #(
    .WIDTH (SDL_CODE_BITS),
    .DEPTH (SDL_FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_valid (upd && clr_f),
    .o_ready (fifo_ready),
    .i_data  (upd_code),
    .o_valid (o_code_valid),
    .i_ready (i_code_ready),
    .o_data  (o_dac_code)
  );

  // checks
  sequence s_auto_done;
    word_done && auto_mode && clr_f;
  endsequence
  auto_update_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_ce and s_auto_done) |=> o_dac_latch == $past(upd_code))
    else $error("auto update did not load latch");
  clear_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && !clr_f |=> o_dac_latch == 12'h000)
    else $error("clear did not zero latch");
  count_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && fs_f |=> bit_cnt == 5'h00)
    else $error("bit counter not cleared");
  gate_limit_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_chain_mode_enable && bit_cnt == 5'h10 |-> !take_bit)
    else $error("bit taken past sixteen");
  count_range_a: assert property (@(posedge i_clk) disable iff (i_reset)
    bit_cnt <= 5'h10)
    else $error("bit counter out of range");
  twos_map_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && clr_f && upd && i_code_format_select |=> o_dac_latch == $past(next_word) ||
    o_dac_latch == $past(held_word))
    else $error("two's complement code altered");
  offset_map_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_auto_done and (i_ce && !i_code_format_select && i_bipolar_range))
    |=> o_dac_latch == ($past(next_word) ^ 12'h800))
    else $error("offset binary msb not inverted");
  defer_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && word_done && !auto_mode && clr_f |=> $stable(o_dac_latch) && o_deferred)
    else $error("deferred frame updated latch early");
endmodule // sdl_loader
`default_nettype wire

/* File: bench/sdl_host_model.sv */
// host serial port model driving the loader's link pins
`timescale 1ns/1ps
`default_nettype none
module sdl_host_model (
  input  wire logic i_clk,           // bench clock, paces the host
  output logic      o_shift_clk,     // shift clock, idle high
  output logic      o_serial_data,   // serial data, msb first
  output logic      o_frame_sync_n,  // frame sync, active low
  output logic      o_latch_load_n   // latch-load strobe, active low
);
  logic host_frame_output;  // active-high framing as the host port makes it

  // the host framing is active high, so it is inverted before the pin
  assign o_frame_sync_n = ~host_frame_output;

  // idle levels: clock parked high, no frame, no load strobe
  initial begin
    o_shift_clk       = 1'b1;
    o_serial_data     = 1'b0;
    o_latch_load_n    = 1'b1;
    host_frame_output = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // one framed burst of n bits, bit n-1 first; 400 ns shift clock
  task automatic send_frame(input logic [31:0] bits, input int n, input logic auto_upd);
    wait_clk(1);
    o_latch_load_n <= ~auto_upd;  // level settles before the frame opens
    wait_clk(4);
    host_frame_output <= 1'b1;
    wait_clk(8);
    for (int k = n - 1; k >= 0; k--) begin
      o_shift_clk   <= 1'b1;
      o_serial_data <= bits[k];  // changes on the rise, valid at the fall
      wait_clk(4);
      o_shift_clk <= 1'b0;
      wait_clk(4);
    end
    o_shift_clk   <= 1'b1;
    o_serial_data <= ~o_serial_data;  // released line must not look held
    wait_clk(4);
    host_frame_output <= 1'b0;
    wait_clk(8);
  endtask

  // timer-style low pulse that commits a deferred word
  task automatic pulse_load();
    wait_clk(1);
    o_latch_load_n <= 1'b0;
    wait_clk(6);
    o_latch_load_n <= 1'b1;
    wait_clk(8);
  endtask
endmodule  // sdl_host_model
`default_nettype wire

/* File: bench/serial_dac_word_loader_tb_top.sv */
// self-checking bench for the serial dac word loader
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); end end
module serial_dac_word_loader_tb_top;
  import sdl_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset, i_ce, i_latch_clear_n, i_code_format_select;
  logic        i_bipolar_range, i_chain_mode_enable, i_code_ready;
  wire  logic  shift_clk, serial_data, frame_sync_n, latch_load_n;
  logic        o_code_valid, o_deferred, o_overflow;
  logic [11:0] o_dac_code, o_dac_latch, head;
  logic [11:0] exp_q[$];
  int          errors = 0, check_count = 0, cycle_count = 0;
  // {format, bipolar, word, expected latch}
  logic [29:0] fmt_tab [6] = '{{2'b00, 16'hA5C3, 12'h5C3}, {2'b01, 16'h07FF, 12'hFFF},
    {2'b01, 16'hF800, 12'h000}, {2'b11, 16'h37FF, 12'h7FF}, {2'b11, 16'h0800, 12'h800},
    {2'b10, 16'hC001, 12'h001}};

  always #25 i_clk = ~i_clk;  // 20 mhz

  sdl_host_model host (.i_clk(i_clk), .o_shift_clk(shift_clk), .o_serial_data(serial_data),
    .o_frame_sync_n(frame_sync_n), .o_latch_load_n(latch_load_n));

  sdl_loader dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_shift_clk(shift_clk),
    .i_serial_data_in(serial_data), .i_frame_sync_n(frame_sync_n),
    .i_latch_load_n(latch_load_n), .i_latch_clear_n(i_latch_clear_n),
    .i_code_format_select(i_code_format_select), .i_bipolar_range(i_bipolar_range),
    .i_chain_mode_enable(i_chain_mode_enable), .i_code_ready(i_code_ready),
    .o_code_valid(o_code_valid), .o_dac_code(o_dac_code), .o_dac_latch(o_dac_latch),
    .o_deferred(o_deferred), .o_overflow(o_overflow));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a word lands in the fifo only while there is room; later ones are lost
  task automatic note(input logic [11:0] exp);
    if (exp_q.size() < SDL_FIFO_DEPTH) exp_q.push_back(exp);
  endtask

  // automatic-update frame, then the latch must hold the mapped code
  task automatic upd(input logic [31:0] bits, input int n, input logic [11:0] exp);
    host.send_frame(bits, n, 1'b1);
    @(negedge i_clk);
    `CHK(o_dac_latch, exp)
    note(exp);
  endtask

  // hang guard, far above the roughly 3200 cycles the run needs
  always @(posedge i_clk) begin
    cycle_count++;
    if (cycle_count == 20000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    i_reset = 1'b1; i_ce = 1'b1; i_latch_clear_n = 1'b1; i_code_format_select = 1'b0;
    i_bipolar_range = 1'b0; i_chain_mode_enable = 1'b0; i_code_ready = 1'b0;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    `CHK(o_dac_latch, SDL_CODE_RESET)
    `CHK({o_deferred, o_overflow, o_code_valid}, 3'b000)
    $display("test reset done");
    // every code format against its expected latch value
    foreach (fmt_tab[k]) begin
      @(posedge i_clk);
      {i_code_format_select, i_bipolar_range} <= fmt_tab[k][29:28];
      upd({16'h0000, fmt_tab[k][27:12]}, 16, fmt_tab[k][11:0]);
    end
    $display("test formats done");
    upd(32'h00012345, 20, 12'h234);
    host.send_frame(32'h0000001F, 5, 1'b1);
    @(negedge i_clk);
    `CHK(o_dac_latch, 12'h234)
    upd(32'h0000BEEF, 16, 12'hEEF);
    $display("test gating done");
    // deferred update waits for the latch-load fall
    host.send_frame(32'h00009ABC, 16, 1'b0);
    @(negedge i_clk);
    `CHK(o_dac_latch, 12'hEEF)
    `CHK(o_deferred, 1'b1)
    host.pulse_load();
    @(negedge i_clk);
    `CHK(o_dac_latch, 12'hABC)
    `CHK(o_deferred, 1'b0)
    note(12'hABC);
    // a latch-load pulse with no waiting word must change nothing
    host.pulse_load();
    @(negedge i_clk);
    `CHK({o_dac_latch, o_deferred}, {12'hABC, 1'b0})
    $display("test deferred done");
    // a frame under clear must not reach the latch
    @(posedge i_clk);
    i_latch_clear_n <= 1'b0;
    host.send_frame(32'h00000123, 16, 1'b1);
    @(negedge i_clk);
    `CHK(o_dac_latch, SDL_CODE_RESET)
    @(posedge i_clk);
    i_latch_clear_n <= 1'b1;
    $display("test clear done");
    // nine words queued so far; the seventeenth overflows the stalled fifo
    for (int k = 0; k < 8; k++) begin
      upd(32'(16'h5A00 + k), 16, 12'(12'hA00 + k));
      if (k == 6) `CHK(o_overflow, 1'b0)
    end
    `CHK(o_overflow, 1'b1)
    while (exp_q.size() > 0) begin
      head = exp_q.pop_front();
      @(negedge i_clk);
      `CHK({o_code_valid, o_dac_code}, {1'b1, head})
      @(posedge i_clk);
      i_code_ready <= 1'b1;
      @(posedge i_clk);
      i_code_ready <= 1'b0;
    end
    @(negedge i_clk);
    `CHK({o_code_valid, o_overflow}, 2'b01)
    $display("test fifo done");
    // chain mode lifts the gate; the update still comes at the sixteenth edge
    i_chain_mode_enable <= 1'b1;
    upd(32'h00012345, 20, 12'h234);
    i_chain_mode_enable <= 1'b0;
    // enable low freezes the synchronisers, so a clear pulse then is never seen
    @(posedge i_clk);
    i_ce <= 1'b0;
    i_latch_clear_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_latch_clear_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_ce <= 1'b1;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    `CHK(o_dac_latch, 12'h234)
    $display("test chain and enable done");
    complete_run();
  end
endmodule  // serial_dac_word_loader_tb_top
`default_nettype wire
